// ---- hdl/dsi_ddr_sync_sram.sv ----
// Purpose: Device side of a DDR burst SRAM with split read/write ports
// Assumes: Link clocks far slower than clock, sampled as plain inputs
// Notes: Storage is a small flip-flop array sized by ADDR_W

`timescale 1ns/10ps
`default_nettype none

module dsi_ddr_sync_sram #(
  parameter int DATA_W = 9,
  parameter int ADDR_W = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic dll_off_n,
  input wire logic [ADDR_W-1:0] shared_address_bus,
  input wire logic [DATA_W-1:0] write_data_in,
  input wire logic [DATA_W/9-1:0] byte_enable_n,
  output logic [DATA_W-1:0] read_data_out,
  output logic read_data_oe,
  output dsi_pkg::dsi_echo_t echo_clock_pair,
  output logic dll_enabled
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  localparam int BE_W = DATA_W / dsi_pkg::BYTE_BITS;
  localparam int MEM_W = ADDR_W + 1;
  localparam int DEPTH = 1 << MEM_W;
  localparam int IN_W = 7 + ADDR_W + DATA_W + BE_W;

  if (DATA_W != 9 && DATA_W != 18 && DATA_W != 36)
  begin : g_bad_width
    $error("DATA_W must be 9, 18 or 36");
  end
  if (ADDR_W < 1 || ADDR_W > 16)
  begin : g_bad_addr
    $error("ADDR_W must be 1 to 16");
  end
  if (BE_W * dsi_pkg::BYTE_BITS != DATA_W)
  begin : g_bad_bytes
    $error("DATA_W must be whole bytes");
  end
  if (dsi_pkg::BURST_LEN != 2)
  begin : g_bad_burst
    $error("Burst index serves two words only");
  end
  if (dsi_pkg::SYNC_DEPTH != 2)
  begin : g_bad_sync
    $error("Sync chain is two stages");
  end
  if (dsi_pkg::STRAP_WAIT != 2'h3)
  begin : g_bad_strap
    $error("Strap must outlast the sync chain fill");
  end

  // ==========================================================
  // Functions
  // ==========================================================
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [BE_W-1:0] be_n
  );
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < BE_W; i++)
    begin
      if (!be_n[i])
      begin
        res[i*dsi_pkg::BYTE_BITS +: dsi_pkg::BYTE_BITS] =
          new_w[i*dsi_pkg::BYTE_BITS +: dsi_pkg::BYTE_BITS];
      end
    end
    return res;
  endfunction

  function automatic logic [MEM_W-1:0] burst_index(
    input logic [ADDR_W-1:0] base,
    input logic word
  );
    return {base, word};
  endfunction

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [IN_W-1:0] pins;
  logic [IN_W-1:0] sync1_reg;
  logic [IN_W-1:0] sync2_reg;
  logic [3:0] clk_prev_reg;
  logic [1:0] strap_cnt_reg;

  assign pins = {k, k_n, c, c_n, read_sel_n, write_sel_n, dll_off_n,
                 shared_address_bus, write_data_in, byte_enable_n};

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      clk_prev_reg <= dsi_pkg::CLK_RST;
    end
    else
    begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      clk_prev_reg <= sync2_reg[IN_W-1 -: 4];
    end
  end

  // ==========================================================
  // Field decode and edge detection
  // ==========================================================
  wire [3:0] clk_s = sync2_reg[IN_W-1 -: 4];
  wire k_s = clk_s[3];
  wire c_s = clk_s[1];
  wire cn_s = clk_s[0];
  wire rsel_n_s = sync2_reg[IN_W-5];
  wire wsel_n_s = sync2_reg[IN_W-6];
  wire dll_n_s = sync2_reg[IN_W-7];
  wire [ADDR_W-1:0] addr_s = sync2_reg[IN_W-8 -: ADDR_W];
  wire [DATA_W-1:0] data_s = sync2_reg[BE_W +: DATA_W];
  wire [BE_W-1:0] be_n_s = sync2_reg[BE_W-1:0];
  // Rises held off until the sync chain holds real pin levels
  wire strap_done = (strap_cnt_reg == dsi_pkg::STRAP_WAIT);
  wire [3:0] clk_raw_rise = clk_s & ~clk_prev_reg;
  wire [3:0] clk_rise = strap_done ? clk_raw_rise : 4'h0;
  wire k_rise = clk_rise[3];
  wire kn_rise = clk_rise[2];

  // ==========================================================
  // Single clock mode strap
  // ==========================================================
  logic single_clk_reg;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      strap_cnt_reg <= 2'h0;
      single_clk_reg <= 1'h0;
    end
    // Last sample taken once the sync chain has filled
    else if (!strap_done)
    begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      single_clk_reg <= c_s & cn_s;
    end
  end

  wire launch_true = single_clk_reg ? k_rise : clk_rise[1];
  wire launch_inv = single_clk_reg ? kn_rise : clk_rise[0];

  // ==========================================================
  // Write port
  // ==========================================================
  logic wr_pend_reg;
  logic [DATA_W-1:0] wr_d0_reg;
  logic [BE_W-1:0] wr_be0_reg;
  logic [DATA_W-1:0] mem_reg [DEPTH];

  wire wr_take = k_rise & ~wsel_n_s;
  wire wr_commit = kn_rise & wr_pend_reg;
  wire [MEM_W-1:0] wr_idx0 = burst_index(addr_s, 1'h0);
  wire [MEM_W-1:0] wr_idx1 = burst_index(addr_s, 1'h1);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'h0;
      wr_d0_reg <= '0;
      wr_be0_reg <= '1;
    end
    else if (k_rise)
    begin
      wr_pend_reg <= wr_take;
      wr_d0_reg <= data_s;
      wr_be0_reg <= be_n_s;
    end
    else if (wr_commit)
    begin
      wr_pend_reg <= 1'h0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (wr_commit)
    begin
      // Both words land together at the k_n edge
      mem_reg[wr_idx0] <= merge_bytes(mem_reg[wr_idx0], wr_d0_reg,
                                      wr_be0_reg);
      mem_reg[wr_idx1] <= merge_bytes(mem_reg[wr_idx1], data_s, be_n_s);
    end
  end

  // ==========================================================
  // Read port
  // ==========================================================
  dsi_pkg::dsi_cmd_t rd_a_reg;
  dsi_pkg::dsi_cmd_t rd_b_reg;
  dsi_pkg::dsi_cmd_t rd_c_reg;
  dsi_pkg::dsi_cmd_t rd_a_next;
  dsi_pkg::dsi_cmd_t rd_b_next;
  dsi_pkg::dsi_cmd_t rd_c_next;
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic rd_oe_reg;
  logic rd_oe_next;

  // Read queue: taken, armed at k_n, then one word per launch
  wire rd_take = k_rise & ~rsel_n_s;
  wire fire0 = launch_inv & rd_b_reg.valid;
  wire fire1 = launch_true & rd_c_reg.valid;
  wire [MEM_W-1:0] rd_idx0 =
    burst_index(rd_b_reg.addr[ADDR_W-1:0], 1'h0);
  wire [MEM_W-1:0] rd_idx1 =
    burst_index(rd_c_reg.addr[ADDR_W-1:0], 1'h1);
  wire idle = ~rd_b_reg.valid & ~rd_c_reg.valid & ~rd_a_reg.valid;

  always_comb
  begin
    rd_a_next = rd_a_reg;
    rd_b_next = rd_b_reg;
    rd_c_next = rd_c_reg;
    rd_data_next = rd_data_reg;
    rd_oe_next = rd_oe_reg;
    if (k_rise)
    begin
      rd_a_next.valid = rd_take;
      rd_a_next.addr = 16'(addr_s);
    end
    if (fire0)
    begin
      rd_data_next = mem_reg[rd_idx0];
      rd_oe_next = 1'h1;
      rd_c_next = rd_b_reg;
      rd_b_next.valid = 1'h0;
    end
    if (fire1)
    begin
      rd_data_next = mem_reg[rd_idx1];
      if (!fire0)
      begin
        rd_c_next.valid = 1'h0;
      end
    end
    // Arming after launch keeps one k_n between them
    if (kn_rise && rd_a_reg.valid)
    begin
      rd_b_next = rd_a_reg;
      rd_a_next.valid = 1'h0;
    end
    // Drivers drop only once nothing is left to launch
    if (k_rise && idle && !fire1)
    begin
      rd_oe_next = 1'h0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rd_a_reg <= '0;
      rd_b_reg <= '0;
      rd_c_reg <= '0;
      rd_data_reg <= '0;
      rd_oe_reg <= 1'h0;
    end
    else
    begin
      rd_a_reg <= rd_a_next;
      rd_b_reg <= rd_b_next;
      rd_c_reg <= rd_c_next;
      rd_data_reg <= rd_data_next;
      rd_oe_reg <= rd_oe_next;
    end
  end

  // ==========================================================
  // Echo clocks and DLL status
  // ==========================================================
  // Echo copies the clock that launches read data
  dsi_pkg::dsi_echo_t echo_reg;
  logic dll_reg;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      echo_reg <= '0;
      dll_reg <= 1'h0;
    end
    else
    begin
      echo_reg.p <= single_clk_reg ? k_s : c_s;
      echo_reg.n <= single_clk_reg ? clk_s[2] : cn_s;
      dll_reg <= dll_n_s;
    end
  end

  assign read_data_out = rd_data_reg;
  assign read_data_oe = rd_oe_reg;
  assign echo_clock_pair = echo_reg;
  assign dll_enabled = dll_reg;

endmodule

`default_nettype wire

// ---- hdl/dsi_pkg.sv ----
// Purpose: Shared constants and types for the DDR sync SRAM interface
// Assumes: Pin inputs are resynchronised to the system clock
// Notes: Widths are module parameters of the top module

package dsi_pkg;

  // ==========================================================
  // Constants
  // ==========================================================
  localparam int SYNC_DEPTH = 2;
  localparam int BYTE_BITS = 9;
  localparam int BURST_LEN = 2;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [3:0] CLK_RST = 4'h0;
  localparam logic CTRL_N_RST = 1'h1;

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } dsi_cmd_t;

  typedef struct packed {
    logic p;
    logic n;
  } dsi_echo_t;

endpackage

// ---- sim/dsi_ddr_sync_sram_monitor.sv ----
// Purpose: Port checker for the SRAM device
// Assumes: Outputs move three clocks after a pin edge
// Notes: Bound to dsi_ddr_sync_sram
`timescale 1ns/10ps
`default_nettype none
// ====
// Checker
module dsi_ddr_sync_sram_monitor #(
  parameter int DATA_W = 9
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic read_sel_n,
  input wire logic dll_off_n,
  input wire logic [DATA_W-1:0] read_data_out,
  input wire logic read_data_oe,
  input wire dsi_pkg::dsi_echo_t echo_clock_pair,
  input wire logic dll_enabled
);
  wire logic one = c && c_n;
  wire logic lt = one ? k : c;
  wire logic ln = one ? k_n : c_n;
  logic lt_reg;
  logic [2:0] up_reg;
  logic [5:0] idle_reg;
  logic [2:0] edge_reg;
  always_ff @(posedge clock)
  begin
    lt_reg <= lt;
    edge_reg <= {edge_reg[1:0], lt != lt_reg};
    up_reg <= !rst_n ? 3'h0 : up_reg + {2'h0, up_reg != 3'h7};
    idle_reg <= (!rst_n || !read_sel_n) ? 6'h00 :
      idle_reg + {5'h00, idle_reg != 6'h3f};
  end
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_data_launch: assert property
    ($changed(read_data_out) |-> edge_reg[2])
    else $error("read data off a launch edge");
  a_out_reset: assert property
    ($rose(rst_n) |-> !read_data_oe && read_data_out == '0)
    else $error("outputs active after reset");
  a_oe_cause: assert property
    ($rose(read_data_oe) |-> idle_reg <= 6'h18)
    else $error("drive without a read");
  a_burst_hold: assert property
    ($rose(read_data_oe) |=> read_data_oe [*7])
    else $error("burst cut short");
  a_deselect_idle: assert property
    (idle_reg > 6'h28 |-> !read_data_oe)
    else $error("drivers left on when idle");
  a_dll_follow: assert property
    (up_reg == 3'h7 |-> dll_enabled == $past(dll_off_n, 3))
    else $error("dll status wrong");
  a_echo_true: assert property
    (up_reg == 3'h7 |-> echo_clock_pair.p == $past(lt, 3))
    else $error("echo true wrong");
  a_echo_comp: assert property
    (up_reg == 3'h7 |-> echo_clock_pair.n == $past(ln, 3))
    else $error("echo comp wrong");
  c_read: cover property ($rose(read_data_oe));
  c_stream: cover property (read_data_oe && !read_sel_n);
  c_single: cover property (one && read_data_oe);
endmodule
bind dsi_ddr_sync_sram dsi_ddr_sync_sram_monitor #(.DATA_W(DATA_W)) i_mon (
  .clock(clock), .rst_n(rst_n), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
  .read_sel_n(read_sel_n), .dll_off_n(dll_off_n),
  .read_data_out(read_data_out), .read_data_oe(read_data_oe),
  .echo_clock_pair(echo_clock_pair), .dll_enabled(dll_enabled));
`default_nettype wire

// ---- sim/dsi_host.sv ----
// Purpose: Host controller model on the SRAM pins
// Assumes: Pins change two clocks after a k edge
// Notes: c lags k a quarter period
`timescale 1ns/10ps
`default_nettype none
// ====
// Host
module dsi_host #(
  parameter int DW = 18,
  parameter int AW = 6
) (
  input wire logic clock,
  input wire logic single,
  output logic k,
  output logic k_n,
  output logic c,
  output logic c_n,
  output logic rs_n,
  output logic ws_n,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] wd,
  output logic [DW/9-1:0] be_n
);
  logic [2:0] ph = 3'h0;
  wire [2:0] phc = ph - 3'h2;
  assign k = ph[2];
  assign k_n = ~k;
  assign c = single | phc[2];
  assign c_n = single | ~phc[2];
  always @(negedge clock) ph <= ph + 3'h1;
  initial
  begin
    rs_n = 1'b1;
    ws_n = 1'b1;
    addr = '0;
    wd = '0;
    be_n = '1;
  end
  task automatic cyc(input logic rd, wr, input logic [AW-1:0] ra, wa,
    input logic [DW-1:0] d0, d1, input logic [DW/9-1:0] be);
  begin
    @(posedge k_n);
    repeat (2) @(negedge clock);
    rs_n = ~rd;
    ws_n = ~wr;
    addr = ra;
    wd = d0;
    be_n = be;
    @(posedge k);
    repeat (2) @(negedge clock);
    rs_n = 1'b1;
    ws_n = 1'b1;
    addr = wa;
    wd = d1;
  end
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the SRAM device
// Assumes: Host model owns bus pins and link clocks; bench drives rst_n and dll_off_n
// Notes: Expected words worked out per test
`timescale 1ns/10ps
`default_nettype none
// ====
// Bench
module tb_top;
  localparam int DW = 18;
  localparam int AW = 6;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic single = 1'b0;
  logic dll_off_n = 1'b0;
  logic k, k_n, c, c_n, rs_n, ws_n, oe, dll_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wd, rdq;
  logic [DW/9-1:0] be_n;
  dsi_pkg::dsi_echo_t echo;
  logic [DW-1:0] exq[$];
  int err_count = 0;
  int comparisons = 0;
  int ticks = 0;
  always #10 clock = ~clock;
  dsi_host #(.DW(DW), .AW(AW)) i_dsi_host (.clock(clock), .single(single),
    .k(k), .k_n(k_n), .c(c), .c_n(c_n), .rs_n(rs_n), .ws_n(ws_n),
    .addr(addr), .wd(wd), .be_n(be_n));
  dsi_ddr_sync_sram #(.DATA_W(DW), .ADDR_W(AW)) i_dsi_ddr_sync_sram (
    .clock(clock), .rst_n(rst_n), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
    .read_sel_n(rs_n), .write_sel_n(ws_n), .dll_off_n(dll_off_n),
    .shared_address_bus(addr), .write_data_in(wd), .byte_enable_n(be_n),
    .read_data_out(rdq), .read_data_oe(oe), .echo_clock_pair(echo),
    .dll_enabled(dll_en));
  task automatic chk(input logic [DW-1:0] got, exp);
  begin
    comparisons++;
    if (got !== exp)
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    if (got !== exp)
      err_count++;
  end
  endtask
  task automatic summarize;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task automatic restart(input logic sing);
  begin
    @(negedge clock);
    rst_n = 1'b0;
    single = sing;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (10) @(negedge clock);
  end
  endtask
  task automatic drain;
  begin
    repeat (60) if (!oe) @(negedge clock);
    while (exq.size() > 0)
    begin
      chk(oe, 1'b1);
      chk(rdq, exq.pop_front());
      if (exq.size() > 0) repeat (4) @(negedge clock);
    end
    repeat (12) @(negedge clock);
    chk(oe, 1'b0);
  end
  endtask
  task automatic t_dll;
  begin
    dll_off_n = 1'b1;
    repeat (6) @(negedge clock);
    chk(dll_en, 1'b1);
    dll_off_n = 1'b0;
    repeat (6) @(negedge clock);
    chk(dll_en, 1'b0);
    dll_off_n = 1'b1;
    $display("dll test done");
  end
  endtask
  task automatic t_echo;
  begin
    @(posedge c);
    repeat (4) @(negedge clock);
    chk(echo.p, 1'b1);
    chk(echo.n, 1'b0);
    repeat (4) @(negedge clock);
    chk(echo.p, 1'b0);
    chk(echo.n, 1'b1);
    $display("echo test done");
  end
  endtask
  task automatic t_rw;
  begin
    i_dsi_host.cyc(1'h0, 1'h1, 6'h00, 6'h05, 18'h12345, 18'h2abcd, 2'h0);
    i_dsi_host.cyc(1'h0, 1'h1, 6'h00, 6'h09, 18'h30f0f, 18'h05a5a, 2'h0);
    i_dsi_host.cyc(1'h0, 1'h1, 6'h00, 6'h05, 18'h3ffff, 18'h3ffff, 2'h2);
    i_dsi_host.cyc(1'h0, 1'h0, 6'h00, 6'h09, 18'h00000, 18'h00000, 2'h0);
    exq = '{18'h123ff, 18'h2abff, 18'h30f0f, 18'h05a5a, 18'h00011, 18'h00022};
    fork
      begin
        i_dsi_host.cyc(1'h1, 1'h1, 6'h05, 6'h0c, 18'h00011, 18'h00022, 2'h0);
        i_dsi_host.cyc(1'h1, 1'h0, 6'h09, 6'h00, 18'h3ffff, 18'h3ffff, 2'h0);
        i_dsi_host.cyc(1'h1, 1'h0, 6'h0c, 6'h00, 18'h3ffff, 18'h3ffff, 2'h0);
      end
      drain();
    join
    $display("write read test done");
  end
  endtask
  task automatic t_single;
  begin
    restart(1'h1);
    exq = '{18'h123ff, 18'h2abff};
    fork
      i_dsi_host.cyc(1'h1, 1'h0, 6'h05, 6'h00, 18'h3ffff, 18'h3ffff, 2'h3);
      drain();
    join
    $display("single clock test done");
  end
  endtask
  initial
  begin
    restart(1'h0);
    t_dll();
    t_echo();
    t_rw();
    t_single();
    summarize();
  end
  always @(posedge clock)
  begin
    ticks++;
    if (ticks == 3000)
    begin
      err_count++;
      summarize();
    end
  end
endmodule
`default_nettype wire
